// ==== rtl/comparator_control_timer_gate.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Enabled comparator stays powered during sleep
// [RULE2] Modes 000 and 111 power comparator down
// [RULE3] Wake needs compare and peripheral irq enables
// [RULE4] Vector to service only with global enable
// [RULE5] Reset restores defaults, mode 000
// [RULE6] Single: switch picks positive or negative input
// [RULE7] Single 101/110 mux inputs, reference non-inverting
// [RULE8] Gate source clear: timer gated by comparator
// [RULE9] Software turns on timer and its gating
// [RULE10] Software should enable sync for gating
// [RULE11] Sync latch captures on falling timer clock
// [RULE12] Latch clock is after the prescaler
// [RULE13] Timer counts on rising edge, no race
// [RULE14] Sync bit 0: latched or asynchronous output
// [RULE15] Gate source bit resets to pin selection
// [RULE16] Invert bit flips each comparator result
// [RULE17] Change flag set on result mismatch
// [RULE18] Mismatch holds until config access or return
// [RULE19] Dual: switch acts only in mux modes
// [RULE20] Result bits read-only, unused bits read zero
module comparator_control_timer_gate
  import cmp_ctrl_pkg::*;
#(
  parameter bit DUAL = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        first_above,
  input  wire logic        second_above,
  input  wire logic        sleeping,
  input  wire logic        timer_clk_tick,
  input  wire logic        timer_gate_pin,
  output logic [2:0]       comparator_mode_select,
  output logic             input_switch_select,
  output logic             first_power_on,
  output logic             second_power_on,
  output logic             first_inv_positive,
  output logic             second_inv_positive,
  output logic             first_result_pin_en,
  output logic             gate_timer_gate,
  output logic             wake_request,
  output logic             irq_vector_request,
  output logic             compare_change_flag
);
  logic [7:0] cfg_r;
  logic [1:0] gate_cfg_r;
  logic [2:0] irq_en_r;
  logic       flag_r;
  logic [1:0] sampled_r;
  logic [1:0] read_latch_r;
  logic       aw_held_r;
  logic       w_held_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] result;
  logic       gate_src;
  logic       cfg_touch;
  logic       wr_fire;
  logic       rd_fire;
  logic [31:0] rd_word;
  logic       mismatch;
  logic       aw_held_nxt;
  logic       w_held_nxt;
  logic       bvalid_nxt;
  logic       rvalid_nxt;

  sync_latch_if sl ();

  gate_sync_latch u_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sl      (sl.latch)
  );

  // True when the mode field powers a comparator down
  function automatic logic mode_off(input logic [2:0] m);
    mode_off = (m == mode_off_reset) || (m == mode_off_dig);  // see [RULE2]
  endfunction

  // Inversion applied to the raw above signal
  always_comb begin
    result[0] = first_above ^ (DUAL ? cfg_r[inv1_bit] : cfg_r[inv1_bit]);  // see [RULE16]
    result[1] = DUAL ? (second_above ^ cfg_r[inv2_bit]) : 1'b0;             // see [RULE16]
  end

  // Comparator 2 gates the timer on the dual part, the only one otherwise
  assign sl.result_in = DUAL ? result[1] : result[0];
  assign sl.sync_en   = gate_cfg_r[sync_bit];
  assign sl.tick      = timer_clk_tick;
  assign gate_src     = gate_cfg_r[gate_src_bit];

  // Bus handshake: both halves held, then one write performed
  assign wr_fire   = aw_held_r && w_held_r && !s_axi_bvalid;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign cfg_touch = (rd_fire && s_axi_araddr == comparator_config_off) ||
                     (wr_fire && aw_addr_r == comparator_config_off);
  assign mismatch  = (sampled_r != read_latch_r);

  // Write address and data are captured independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r[1:0] != 2'h0) ? resp_slverr :
                        (aw_addr_r == status_off) ? resp_slverr : resp_okay;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Handshake state one edge ahead, so the ready outputs can be flops
  always_comb begin
    aw_held_nxt = !wr_fire && (aw_held_r || (s_axi_awvalid && s_axi_awready));
    w_held_nxt  = !wr_fire && (w_held_r || (s_axi_wvalid && s_axi_wready));
    bvalid_nxt  = wr_fire || (s_axi_bvalid && !s_axi_bready);
    rvalid_nxt  = rd_fire || (s_axi_rvalid && !s_axi_rready);
  end

  // Ready is low while a half is held or an answer waits; costs one
  // idle cycle after reset but keeps every top output registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
      s_axi_wready  <= !w_held_nxt && !bvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
    end
  end

  // Configuration registers; result bits cannot be written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r      <= comparator_config_rst;              // see [RULE5]
      gate_cfg_r <= gate_sync_config_rst[1:0];          // see [RULE5] see [RULE15]
      irq_en_r   <= irq_control_rst[2:0];
    end else if (wr_fire && w_strb_r[0]) begin
      case (aw_addr_r)
        comparator_config_off: begin
          cfg_r[3:0] <= w_data_r[3:0];
          cfg_r[inv1_bit] <= w_data_r[inv1_bit];
          cfg_r[inv2_bit] <= DUAL ? w_data_r[inv2_bit] : 1'b0;  // see [RULE20]
        end
        gate_sync_config_off: gate_cfg_r <= w_data_r[1:0];
        irq_control_off: irq_en_r <= w_data_r[2:0];
        default: ;
      endcase
    end
  end

  // Mismatch circuit: one stage sampled every cycle, one on config access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sampled_r    <= 2'b00;
      read_latch_r <= 2'b00;
    end else begin
      sampled_r <= result;                               // see [RULE17]
      if (cfg_touch) begin
        read_latch_r <= sampled_r;                       // see [RULE18]
      end
    end
  end

  // Change flag: hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else if (mismatch && !cfg_touch) begin
      flag_r <= 1'b1;                                    // see [RULE17] see [RULE18]
    end else if (wr_fire && w_strb_r[0] && aw_addr_r == irq_control_off) begin
      flag_r <= w_data_r[flag_bit];
    end
  end

  // Read data mux; unimplemented bits return zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      comparator_config_off: begin
        rd_word[3:0] = cfg_r[3:0];
        rd_word[inv1_bit] = cfg_r[inv1_bit];
        if (DUAL) begin
          rd_word[inv2_bit]    = cfg_r[inv2_bit];
          rd_word[result1_bit] = sampled_r[0];
          rd_word[result2_bit] = sampled_r[1];           // see [RULE20]
        end else begin
          rd_word[single_res_bit] = sampled_r[0];        // see [RULE20]
        end
      end
      gate_sync_config_off: rd_word[1:0] = gate_cfg_r;
      status_off: rd_word[1:0] = sampled_r;
      irq_control_off: rd_word[3:0] = {flag_r, irq_en_r};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= resp_okay;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (s_axi_araddr[1:0] != 2'h0) ? resp_slverr : resp_okay;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Analog control outputs, registered; power ignores sleep on purpose
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comparator_mode_select <= mode_off_reset;
      input_switch_select    <= 1'b0;
      first_power_on         <= 1'b0;
      second_power_on        <= 1'b0;
      first_inv_positive     <= 1'b0;
      second_inv_positive    <= 1'b0;
      first_result_pin_en    <= 1'b0;
      gate_timer_gate        <= 1'b1;
      wake_request           <= 1'b0;
      irq_vector_request     <= 1'b0;
      compare_change_flag    <= 1'b0;
    end else begin
      comparator_mode_select <= cfg_r[2:0];
      input_switch_select    <= cfg_r[input_switch_bit_f()];
      first_power_on  <= !mode_off(cfg_r[2:0]);          // see [RULE1] see [RULE2]
      second_power_on <= DUAL && !mode_off(cfg_r[2:0]) &&
                         cfg_r[2:0] != mode_dual_one;    // see [RULE1]
      if (DUAL) begin
        // Switch acts only in the multiplexed modes
        first_inv_positive  <= (cfg_r[2:0] == mode_dual_one ||
                                cfg_r[2:0] == mode_dual_two) &&
                               cfg_r[input_sw_bit];      // see [RULE19]
        second_inv_positive <= (cfg_r[2:0] == mode_dual_two) &&
                               cfg_r[input_sw_bit];      // see [RULE19]
        first_result_pin_en <= (cfg_r[2:0] == mode_mux_int);
      end else begin
        first_inv_positive  <= (cfg_r[2:0] == mode_mux_pin ||
                                cfg_r[2:0] == mode_mux_int) &&
                               cfg_r[input_sw_bit];      // see [RULE6] see [RULE7]
        second_inv_positive <= 1'b0;
        first_result_pin_en <= (cfg_r[2:0] == mode_mux_pin) ||
                               (cfg_r[2:0] == mode_dual_one) ||
                               (cfg_r[2:0] == 3'h3);     // see [RULE7]
      end
      // Gate follows comparator when source bit clear, else the pin
      gate_timer_gate <= gate_src ? timer_gate_pin : sl.latched;  // see [RULE8] see [RULE15]
      wake_request    <= sleeping && flag_r && irq_en_r[irq_en_bit] &&
                         irq_en_r[periph_en_bit];        // see [RULE3]
      // Vectoring only when awake, so the next instruction runs first
      irq_vector_request <= !sleeping && flag_r && irq_en_r[irq_en_bit] &&
                            irq_en_r[periph_en_bit] &&
                            irq_en_r[global_en_bit];     // see [RULE4]
      compare_change_flag <= flag_r;
    end
  end

  function automatic int input_switch_bit_f();
    input_switch_bit_f = input_sw_bit;
  endfunction
endmodule

// ==== inc/cmp_ctrl_pkg.sv ====
package cmp_ctrl_pkg;
  // Register byte offsets
  localparam logic [3:0] comparator_config_off = 4'h0;
  localparam logic [3:0] gate_sync_config_off  = 4'h4;
  localparam logic [3:0] status_off            = 4'h8;
  localparam logic [3:0] irq_control_off       = 4'hC;
  // Comparator configuration field positions
  localparam int mode_lsb       = 0;
  localparam int input_sw_bit   = 3;
  localparam int inv1_bit       = 4;
  localparam int inv2_bit       = 5;
  localparam int result1_bit    = 6;
  localparam int result2_bit    = 7;
  localparam int single_res_bit = 6;
  // Gate sync configuration fields
  localparam int sync_bit       = 0;
  localparam int gate_src_bit   = 1;
  // Interrupt control fields
  localparam int irq_en_bit     = 0;
  localparam int periph_en_bit  = 1;
  localparam int global_en_bit  = 2;
  localparam int flag_bit       = 3;
  // Reset values
  localparam logic [7:0] comparator_config_rst = 8'h00;
  localparam logic [7:0] gate_sync_config_rst  = 8'h02;
  localparam logic [3:0] irq_control_rst       = 4'h0;
  // Comparator modes
  localparam logic [2:0] mode_off_reset = 3'h0;
  localparam logic [2:0] mode_mux_pin   = 3'h5;
  localparam logic [2:0] mode_mux_int   = 3'h6;
  localparam logic [2:0] mode_off_dig   = 3'h7;
  localparam logic [2:0] mode_dual_one  = 3'h1;
  localparam logic [2:0] mode_dual_two  = 3'h2;
  // AXI responses
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ==== inc/sync_latch_if.sv ====
`timescale 1ns/1ps
interface sync_latch_if;
  logic result_in;
  logic sync_en;
  logic tick;
  logic latched;
  modport ctrl  (output result_in, output sync_en, output tick, input latched);
  modport latch (input result_in, input sync_en, input tick, output latched);
endinterface

// ==== rtl/gate_sync_latch.sv ====
`timescale 1ns/1ps
// Latches the gate comparator result on the falling edge of the
// prescaled timer clock, so the timer (rising edge) never races it
module gate_sync_latch
  import cmp_ctrl_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  sync_latch_if.latch sl
);
  logic tick_d_r;
  logic held_r;

  // Falling edge of the prescaled clock; tick is after prescaling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_d_r <= 1'b0;
      held_r   <= 1'b0;
    end else begin
      tick_d_r <= sl.tick;
      if (tick_d_r && !sl.tick) begin
        held_r <= sl.result_in;  // see [RULE11] see [RULE12] see [RULE13]
      end
    end
  end

  // Unsynchronised path passes straight through
  assign sl.latched = sl.sync_en ? held_r : sl.result_in;  // see [RULE14]
endmodule

// ==== tb/cmp_far_model.sv ====
`timescale 1ns/1ps
// Far side: prescaled timer clock and the 16-bit gate timer
module cmp_far_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        gate_timer_gate,
  output logic             timer_clk_tick,
  output logic [15:0]      gate_count_r
);
  logic [1:0] div_r;
  logic       tick_d_r;
  // Tick is already prescaled, half period four cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 2'h0;
      timer_clk_tick <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) timer_clk_tick <= ~timer_clk_tick;
    end
  end
  // Count on the rising tick so the falling-edge latch never races it
  always_ff @(posedge aclk) begin
    tick_d_r <= timer_clk_tick;
    if (!aresetn) gate_count_r <= 16'h0000;
    else if (timer_clk_tick && !tick_d_r && gate_timer_gate) begin
      gate_count_r <= gate_count_r + 16'h0001; // rising edge
    end
  end
endmodule

// ==== tb/cmp_ctrl_chk.sv ====
`timescale 1ns/1ps
module cmp_ctrl_chk
  import cmp_ctrl_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       sleeping,
  input wire logic [2:0] comparator_mode_select,
  input wire logic       input_switch_select,
  input wire logic       first_power_on,
  input wire logic       second_power_on,
  input wire logic       first_inv_positive,
  input wire logic       second_inv_positive,
  input wire logic       gate_timer_gate,
  input wire logic       wake_request,
  input wire logic       irq_vector_request,
  input wire logic       compare_change_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Two quiet cycles let registered outputs follow a config write
  sequence cfg_held;
    $stable({comparator_mode_select, input_switch_select})[*2];
  endsequence
  sequence off_mode;
    comparator_mode_select == mode_off_reset || comparator_mode_select == mode_off_dig;
  endsequence
  sequence mux_mode;
    comparator_mode_select == mode_dual_one || comparator_mode_select == mode_dual_two;
  endsequence
  power_off_a: assert property (cfg_held ##0 off_mode |->
      !first_power_on && !second_power_on)
    else $error("comparator powered in off mode");
  power_on_a: assert property (cfg_held ##0
      comparator_mode_select inside {[3'h1:3'h6]} |-> first_power_on)
    else $error("comparator off in active mode");
  switch_one_a: assert property (cfg_held ##0 mux_mode |->
      first_inv_positive == input_switch_select)
    else $error("first input switch wrong");
  switch_two_a: assert property (cfg_held ##0
      comparator_mode_select == mode_dual_two |-> second_inv_positive == input_switch_select)
    else $error("second input switch wrong");
  // Flag output and wake or vector output are launched by the same internal flag
  wake_cause_a: assert property (wake_request |->
      $past(sleeping) && compare_change_flag)
    else $error("wake without sleep and flag");
  vector_cause_a: assert property (irq_vector_request |->
      !$past(sleeping) && compare_change_flag)
    else $error("vector while asleep or no flag");
  wake_vector_a: assert property (!(wake_request && irq_vector_request))
    else $error("wake and vector together");
  reset_state_a: assert property (disable iff (1'b0) !aresetn |=>
      gate_timer_gate && comparator_mode_select == 3'h0 && !compare_change_flag)
    else $error("reset state wrong");
endmodule
bind comparator_control_timer_gate cmp_ctrl_chk chk_u (.aclk, .aresetn, .sleeping,
  .comparator_mode_select, .input_switch_select, .first_power_on, .second_power_on,
  .first_inv_positive, .second_inv_positive, .gate_timer_gate, .wake_request,
  .irq_vector_request, .compare_change_flag);

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top
  import cmp_ctrl_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, first_above, second_above, sleeping, timer_gate_pin;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [2:0]  comparator_mode_select;
  logic        input_switch_select, first_power_on, second_power_on, first_inv_positive;
  logic        second_inv_positive, first_result_pin_en, gate_timer_gate, wake_request;
  logic        irq_vector_request, compare_change_flag, timer_clk_tick;
  logic [15:0] gate_count;
  int          err_count, samples_checked, seed, cnt, cfg_m;
  comparator_control_timer_gate #(.DUAL(1'b1)) dut_u (.*);
  cmp_far_model far_u (.aclk, .aresetn, .gate_timer_gate, .timer_clk_tick,
    .gate_count_r(gate_count));
  always #50 aclk = ~aclk;
  // Expected config read: results follow the levels, flipped by the invert bits
  function automatic logic [31:0] cfg_x();
    return {24'h0, second_above ^ cfg_m[5], first_above ^ cfg_m[4], cfg_m[5:0]};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    summarize();
  end
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, first_above, second_above, sleeping} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'hF};
    {timer_gate_pin, err_count, samples_checked, seed, cfg_m} = {1'b1, 64'h0, 32'h8D2D, 32'h0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(comparator_config_off);
    `CHK(rd, cfg_x()) // defaults
    rdr(gate_sync_config_off);
    `CHK(rd, 32'h2) // pin gate
    `CHK(gate_timer_gate, 1'b1) // pin level
    cnt = gate_count;
    repeat (20) @(posedge aclk);
    `CHK(gate_count > cnt, 1'b1) // counting
    wr(status_off, 32'hFF);
    `CHK(resp, resp_slverr) // read-only place
    wr(4'h2, 32'h1);
    `CHK(resp, resp_slverr) // misaligned refused
    wr(gate_sync_config_off, 32'hFFFFFFFC); // comparator gate, async
    rdr(gate_sync_config_off);
    `CHK(rd, 32'h0) // unused bits zero
    // Every mode with random switch, inversion, levels and sleep
    for (int m = 0; m < 8; m++) begin
      {first_above, second_above, sleeping} <= 3'($random(seed));
      cfg_m = ({$random(seed)} & 32'h38) | m;
      wr(comparator_config_off, cfg_m | 32'hC0);
      repeat (2) @(posedge aclk);
      `CHK(first_power_on, (m != 0 && m != 7)) // power
      `CHK(second_power_on && (m == 0 || m == 7), 1'b0) // power
      `CHK(comparator_mode_select, m[2:0]) // mode held
      `CHK(input_switch_select, cfg_m[3]) // switch bit
      `CHK(first_inv_positive, (m == 1 || m == 2) && cfg_m[3])
      `CHK(second_inv_positive, m == 2 && cfg_m[3])
      `CHK(first_result_pin_en, m == 6) // result pin only in mode 110
      rdr(comparator_config_off);
      `CHK(rd, cfg_x()) // results
      `CHK(gate_timer_gate, second_above ^ cfg_m[5]) // gate source
    end
    wr(gate_sync_config_off, 32'h1); // sync advised
    cfg_m = 4;
    wr(comparator_config_off, 32'h4);
    // Let one latch fall pass so the held value reflects this setup
    repeat (8) @(posedge aclk);
    do @(posedge aclk); while (timer_clk_tick);
    do @(posedge aclk); while (!timer_clk_tick);
    cnt = second_above;
    second_above <= ~second_above;
    repeat (2) @(posedge aclk);
    `CHK(gate_timer_gate, cnt[0]) // held until fall
    do @(posedge aclk); while (timer_clk_tick);
    repeat (3) @(posedge aclk);
    `CHK(gate_timer_gate, ~cnt[0]) // latched
    // End the old mismatch first so the clear really lands
    sleeping <= 1'b0;
    rdr(comparator_config_off);
    wr(irq_control_off, 32'h3);
    first_above <= ~first_above;
    repeat (4) @(posedge aclk);
    `CHK(compare_change_flag, 1'b1) // mismatch
    sleeping <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(wake_request, 1'b1) // wake
    `CHK(irq_vector_request, 1'b0) // no vector
    sleeping <= 1'b0;
    rdr(comparator_config_off);
    wr(irq_control_off, 32'h3);
    repeat (2) @(posedge aclk);
    `CHK(compare_change_flag, 1'b0) // cleared
    wr(irq_control_off, 32'h7);
    second_above <= ~second_above;
    repeat (4) @(posedge aclk);
    `CHK(irq_vector_request, 1'b1) // vector
    rdr(irq_control_off);
    `CHK(rd, 32'hF) // flag bit
    // Second reset mid-run
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cfg_m = 0;
    rdr(comparator_config_off);
    `CHK(rd, cfg_x()) // defaults again
    summarize();
  end
endmodule
